// [core/dlcm_pkg.sv]
// Purpose: constants and types for the delay-locked clock manager
// Assumes: MCLK at 125 MHz, source clocks sampled as synchronous levels
// Notes:   byte offsets, field positions and timing counts live here
// Summary of operation
// - lock rises only after phase lock reached
// - pre-lock outputs unreliable; doubled is 25/75 1x
// - hold-startup option waits for lock; default off
// - duty fix gives 50/50 phase outputs; default on
// - divided output = phase zero over ratio
// - one loop, its source one of four lanes chosen by placement index
// - locked loop tolerates 1 ns period drift
// - lock stays high across legal clock pause
// - one to four clocks flush and fill
// - input phase shift reaches outputs shortly, undisturbed
// - phase zero is aligned copy of source
// - other phases lag by 25, 50, 75 percent
// - high-frequency odd ratios give 33.3/40 percent high
// - high-frequency mode drops 90 and 270 outputs
package dlcm_pkg;
   localparam int          PW            = 12;
   localparam int          DW            = 17;
   localparam logic [3:0]  OFF_CTRL      = 4'h0;
   localparam logic [3:0]  OFF_STATUS    = 4'h4;
   localparam logic [3:0]  OFF_PERIOD    = 4'h8;
   localparam int          DUTY_BIT      = 0;
   localparam int          HOLD_BIT      = 1;
   localparam int          FAST_BIT      = 2;
   localparam int          DIV_LSB       = 4;
   localparam int          PLACE_LSB     = 8;
   localparam int          LRST_BIT      = 12;
   localparam int          HIGH_LSB      = 16;
   localparam logic [31:0] CTRL_RESET    = 32'h0000_0011;
   localparam int          MCLK_PS       = 8000;
   localparam int          DRIFT_PS      = 1000;
   localparam int          DRIFT_RAW     = DRIFT_PS / MCLK_PS;
   localparam logic [PW-1:0] DRIFT_CYC   = (DRIFT_RAW < 1) ? PW'(1) : PW'(DRIFT_RAW);
   localparam logic [PW-1:0] LOCK_EDGES  = 12'hBB8;
   localparam logic [2:0]  FLUSH_CLKS    = 3'h2;
   localparam logic [2:0]  FILL_CLKS     = 3'h2;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'h0,
      ST_FILL  = 2'h1,
      ST_RUN   = 2'h3,
      ST_FLUSH = 2'h2
   } dlcm_state_t;

   // ratio in half periods of phase zero: 1.5,2,2.5,3,4,5,8,16
   function automatic logic [5:0] dlcm_halves(input logic [2:0] code);
      logic [5:0] h;
      h = 6'h04;
      case (code)
         3'h0:    h = 6'h03;
         3'h1:    h = 6'h04;
         3'h2:    h = 6'h05;
         3'h3:    h = 6'h06;
         3'h4:    h = 6'h08;
         3'h5:    h = 6'h0A;
         3'h6:    h = 6'h10;
         default: h = 6'h20;
      endcase
      return h;
   endfunction
endpackage

// [core/dlcm_lock_det.sv]
// Purpose: measures source period and high time, decides lock
// Assumes: src is a level sampled on MCLK
// Notes:   lock is only lost through reset
`timescale 1ns/10ps
module dlcm_lock_det
   import dlcm_pkg::*;
(
   input  wire logic          clk,
   input  wire logic          rst_n,
   input  wire logic          src,
   output logic               src_rise,
   output logic [PW-1:0]      period,
   output logic [PW-1:0]      high_time,
   output logic               locked
);
   logic          src_r, src_nxt;
   logic [PW-1:0] cnt_r, cnt_nxt, per_r, per_nxt, hi_r, hi_nxt, stb_r, stb_nxt;
   logic          lck_r, lck_nxt;
   logic [PW-1:0] meas, diff;

   always_comb begin
      src_nxt  = src;
      src_rise = src & ~src_r;
      meas     = cnt_r + PW'(1);
      diff     = (meas > per_r) ? meas - per_r : per_r - meas;
      cnt_nxt  = src_rise ? '0 : ((&cnt_r) ? cnt_r : meas);
      per_nxt  = src_rise ? meas : per_r;
      hi_nxt   = (~src & src_r) ? meas : hi_r;
      stb_nxt  = stb_r;
      lck_nxt  = lck_r;
      if (src_rise) begin
         if (per_r != '0 && diff <= DRIFT_CYC) begin
            stb_nxt = (stb_r == LOCK_EDGES) ? stb_r : stb_r + PW'(1);
            if (stb_r == LOCK_EDGES - PW'(1))
               lck_nxt = 1'b1;
         end else begin
            stb_nxt = '0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         src_r <= 1'b0;
         cnt_r <= '0;
         per_r <= '0;
         hi_r  <= '0;
         stb_r <= '0;
         lck_r <= 1'b0;
      end else begin
         src_r <= src_nxt;
         cnt_r <= cnt_nxt;
         per_r <= per_nxt;
         hi_r  <= hi_nxt;
         stb_r <= stb_nxt;
         lck_r <= lck_nxt;
      end
   end

   assign period    = per_r;
   assign high_time = hi_r;
   assign locked    = lck_r;

   chk_lock_after_run: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(lck_r) |-> $past(stb_r) == LOCK_EDGES - PW'(1))
      else $error("lock rose before stable run completed");
endmodule

// [core/dlcm_avmm.sv]
// Purpose: Avalon-MM slave holding control and returning status
// Assumes: word-aligned byte addresses, one wait state per access
// Notes:   unmapped reads return zero, unmapped writes are dropped
`timescale 1ns/10ps
module dlcm_avmm
   import dlcm_pkg::*;
(
   input  wire logic          clk,
   input  wire logic          rst_n,
   input  wire logic [3:0]    address,
   input  wire logic          read,
   input  wire logic          write,
   input  wire logic [31:0]   writedata,
   input  wire logic [3:0]    byteenable,
   input  wire logic [31:0]   status,
   input  wire logic [31:0]   period_word,
   output logic [31:0]        readdata,
   output logic               waitrequest,
   output logic [31:0]        ctrl,
   output logic               loop_rst
);
   logic        ack_r, ack_nxt, lrst_r, lrst_nxt;
   logic [31:0] ctrl_r, ctrl_nxt, rd_r, rd_nxt;
   logic        wr_go;

   always_comb begin
      ack_nxt  = (read | write) & ~ack_r;
      wr_go    = write & ack_r;
      ctrl_nxt = ctrl_r;
      lrst_nxt = 1'b0;
      rd_nxt   = rd_r;
      if (wr_go && address == OFF_CTRL) begin
         for (int b = 0; b < 4; b++) begin
            if (byteenable[b])
               ctrl_nxt[8*b +: 8] = writedata[8*b +: 8];
         end
         lrst_nxt = byteenable[LRST_BIT/8] & writedata[LRST_BIT];
         ctrl_nxt[LRST_BIT] = 1'b0;
      end
      if (read && !ack_r) begin
         case (address)
            OFF_CTRL:   rd_nxt = ctrl_r;
            OFF_STATUS: rd_nxt = status;
            OFF_PERIOD: rd_nxt = period_word;
            default:    rd_nxt = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ack_r  <= 1'b0;
         ctrl_r <= CTRL_RESET;
         lrst_r <= 1'b0;
         rd_r   <= 32'h0000_0000;
      end else begin
         ack_r  <= ack_nxt;
         ctrl_r <= ctrl_nxt;
         lrst_r <= lrst_nxt;
         rd_r   <= rd_nxt;
      end
   end

   assign waitrequest = (read | write) & ~ack_r;
   assign readdata    = rd_r;
   assign ctrl        = ctrl_r;
   assign loop_rst    = lrst_r;

   chk_wait_single: assert property (@(posedge clk) disable iff (!rst_n)
      (read | write) && waitrequest |=> !waitrequest)
      else $error("access held longer than one wait state");
endmodule

// [core/dlcm_top.sv]
// Purpose: digital delay-locked clock manager with four phases,
//          doubled and divided clocks, lock flag and startup gate
// Assumes: source clocks are much slower than MCLK, period >= 4 MCLK
// Notes:   output clocks are MCLK-sampled waveforms, so edges are
//          quantised to 8 ns; one source lane per placement index
`timescale 1ns/10ps
module dlcm_top
   import dlcm_pkg::*;
(
   input  wire logic          MCLK,
   input  wire logic          RESETN,
   input  wire logic [3:0]    SOURCE_CLOCK_IN,
   input  wire logic          CFG_DONE,
   input  wire logic [3:0]    AVS_ADDRESS,
   input  wire logic          AVS_READ,
   input  wire logic          AVS_WRITE,
   input  wire logic [31:0]   AVS_WRITEDATA,
   input  wire logic [3:0]    AVS_BYTEENABLE,
   output logic [31:0]        AVS_READDATA,
   output logic               AVS_WAITREQUEST,
   output logic               PHASE_ZERO_CLOCK_OUT,
   output logic               QUARTER_PHASE_CLOCK_OUT,
   output logic               HALF_PHASE_CLOCK_OUT,
   output logic               THREE_QUARTER_PHASE_CLOCK_OUT,
   output logic               DOUBLED_CLOCK_OUT,
   output logic               DIVIDED_CLOCK_OUT,
   output logic               LOCKED,
   output logic               STARTUP_RELEASE
);
   logic [31:0]   ctrl, status_w, period_w;
   logic          loop_rst, loop_rst_n;
   logic          duty_fix, hold_start, fast_mode;
   logic [2:0]    div_code;
   logic [1:0]    place_idx;
   logic          src_sel, src_rise, locked;
   logic [PW-1:0] per, hi_t;

   assign duty_fix   = ctrl[DUTY_BIT];
   assign hold_start = ctrl[HOLD_BIT];
   assign fast_mode  = ctrl[FAST_BIT];
   assign div_code   = ctrl[DIV_LSB +: 3];
   assign place_idx  = ctrl[PLACE_LSB +: 2];
   assign src_sel    = SOURCE_CLOCK_IN[place_idx];
   // a manual reset clears lock next edge and reacquires from scratch
   assign loop_rst_n = RESETN & ~loop_rst;

   dlcm_avmm u_regs (
      .clk         (MCLK),
      .rst_n       (RESETN),
      .address     (AVS_ADDRESS),
      .read        (AVS_READ),
      .write       (AVS_WRITE),
      .writedata   (AVS_WRITEDATA),
      .byteenable  (AVS_BYTEENABLE),
      .status      (status_w),
      .period_word (period_w),
      .readdata    (AVS_READDATA),
      .waitrequest (AVS_WAITREQUEST),
      .ctrl        (ctrl),
      .loop_rst    (loop_rst)
   );

   dlcm_lock_det u_lock (
      .clk       (MCLK),
      .rst_n     (loop_rst_n),
      .src       (src_sel),
      .src_rise  (src_rise),
      .period    (per),
      .high_time (hi_t),
      .locked    (locked)
   );

   dlcm_state_t   st_r, st_nxt;
   logic [PW-1:0] ph_r, ph_nxt;
   logic [2:0]    cnt_r, cnt_nxt;
   logic [DW-1:0] dv_r, dv_nxt;
   logic [3:0]    ck_r, ck_nxt;
   logic          dbl_r, dbl_nxt, dvo_r, dvo_nxt, start_r, start_nxt;
   logic [PW-1:0] wrap, q_off, h_off, tq_off, thr;
   logic          miss, active, in_per;
   logic [5:0]    halves;
   logic [DW-1:0] dv_total, dv_high;
   logic [PW-1:0] offs [4];

   always_comb begin
      // the wrap point allows one drift step so a late edge is not a miss
      wrap   = per + DRIFT_CYC;
      miss   = ~src_rise & (ph_r == wrap);
      q_off  = per >> 2;
      h_off  = per >> 1;
      tq_off = q_off + h_off;
      thr    = duty_fix ? h_off : hi_t;
      active = (st_r == ST_RUN) | (st_r == ST_FLUSH);
      in_per = ph_r < per;
      offs[0] = '0;
      offs[1] = q_off;
      offs[2] = h_off;
      offs[3] = tq_off;
   end

   // phase counter restarts on every source rise, so an input phase
   // shift moves the phase and doubled outputs two MCLK cycles after the shifted rise, without touching lock
   always_comb begin
      ph_nxt  = (src_rise | miss) ? '0 : ph_r + PW'(1);
      st_nxt  = st_r;
      cnt_nxt = cnt_r;
      case (st_r)
         ST_IDLE: begin
            if (src_rise && per != '0) begin
               st_nxt  = ST_FILL;
               cnt_nxt = 3'h1;
            end
         end
         ST_FILL: begin
            if (miss) begin
               st_nxt = ST_IDLE;
            end else if (src_rise) begin
               if (cnt_r == FILL_CLKS) begin
                  st_nxt  = ST_RUN;
                  cnt_nxt = 3'h0;
               end else begin
                  cnt_nxt = cnt_r + 3'h1;
               end
            end
         end
         ST_RUN: begin
            if (miss) begin
               st_nxt  = ST_FLUSH;
               cnt_nxt = 3'h1;
            end
         end
         ST_FLUSH: begin
            if (src_rise) begin
               st_nxt  = ST_FILL;
               cnt_nxt = 3'h1;
            end else if (miss) begin
               if (cnt_r == FLUSH_CLKS)
                  st_nxt = ST_IDLE;
               else
                  cnt_nxt = cnt_r + 3'h1;
            end
         end
         default: begin
            st_nxt  = ST_IDLE;
            cnt_nxt = 3'h0;
         end
      endcase
   end

   // lock is untouched by the state machine: a legal pause keeps it
   assign LOCKED = locked;

   generate
      for (genvar k = 0; k < 4; k++) begin : g_phase
         logic [PW-1:0] rel;
         logic          drop;
         always_comb begin
            rel  = (ph_r >= offs[k]) ? ph_r - offs[k] : ph_r + per - offs[k];
            drop = fast_mode & ((k == 1) | (k == 3));
            ck_nxt[k] = active & in_per & ~drop & (rel < thr);
         end
      end
   endgenerate

   always_comb begin
      // before lock the doubled output is a quarter-duty 1x clock
      if (locked)
         dbl_nxt = active & in_per & ((ph_r < q_off) | ((ph_r >= h_off) & (ph_r < tq_off)));
      else
         dbl_nxt = active & in_per & (ph_r < q_off);
      halves   = dlcm_halves(div_code);
      dv_total = DW'((DW'(per) * DW'(halves)) >> 1);
      // odd ratios in high-frequency mode keep whole high half-periods
      if (fast_mode)
         dv_high = DW'((DW'(per) * DW'(halves >> 1)) >> 1);
      else
         dv_high = dv_total >> 1;
      if (!active || dv_r >= dv_total - DW'(1))
         dv_nxt = '0;
      else
         dv_nxt = dv_r + DW'(1);
      dvo_nxt   = active & (dv_r < dv_high);
      start_nxt = start_r | (CFG_DONE & (~hold_start | locked));
   end

   always_ff @(posedge MCLK) begin
      if (!loop_rst_n) begin
         st_r  <= ST_IDLE;
         ph_r  <= '0;
         cnt_r <= 3'h0;
         dv_r  <= '0;
         ck_r  <= 4'h0;
         dbl_r <= 1'b0;
         dvo_r <= 1'b0;
      end else begin
         st_r  <= st_nxt;
         ph_r  <= ph_nxt;
         cnt_r <= cnt_nxt;
         dv_r  <= dv_nxt;
         ck_r  <= ck_nxt;
         dbl_r <= dbl_nxt;
         dvo_r <= dvo_nxt;
      end
   end

   // startup release survives a loop reset: start-up happens once
   always_ff @(posedge MCLK) begin
      if (!RESETN)
         start_r <= 1'b0;
      else
         start_r <= start_nxt;
   end

   assign PHASE_ZERO_CLOCK_OUT          = ck_r[0];
   assign QUARTER_PHASE_CLOCK_OUT       = ck_r[1];
   assign HALF_PHASE_CLOCK_OUT          = ck_r[2];
   assign THREE_QUARTER_PHASE_CLOCK_OUT = ck_r[3];
   assign DOUBLED_CLOCK_OUT             = dbl_r;
   assign DIVIDED_CLOCK_OUT             = dvo_r;
   assign STARTUP_RELEASE               = start_r;
   assign status_w = {27'h0, active, st_r, start_r, locked};
   assign period_w = {4'h0, hi_t, 4'h0, per};

   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RESETN);

   sequence s_run_rise;
      st_r == ST_RUN && src_rise && !miss && duty_fix && per >= PW'(4);
   endsequence
   sequence s_pause;
      st_r == ST_FLUSH && !src_rise;
   endsequence

   chk_lock_reset_drop: assert property (loop_rst |=> !LOCKED)
      else $error("lock not cleared by manual reset");
   chk_lock_stays: assert property (LOCKED && !loop_rst |=> LOCKED)
      else $error("lock dropped without reset");
   chk_pause_lock: assert property (s_pause ##1 s_pause |-> LOCKED == $past(LOCKED, 2))
      else $error("lock changed during pause");
   chk_startup_gate: assert property ($rose(STARTUP_RELEASE) |->
      $past(CFG_DONE) && (!$past(hold_start) || $past(locked)))
      else $error("startup released before lock");
   chk_idle_quiet: assert property (st_r == ST_IDLE || st_r == ST_FILL |=>
      !PHASE_ZERO_CLOCK_OUT && !DOUBLED_CLOCK_OUT && !DIVIDED_CLOCK_OUT)
      else $error("output clock during fill or idle");
   chk_fast_no_quarter: assert property (fast_mode |=>
      !QUARTER_PHASE_CLOCK_OUT && !THREE_QUARTER_PHASE_CLOCK_OUT)
      else $error("quarter phases active in high-frequency mode");
   chk_phase0_align: assert property (s_run_rise |-> ##2 PHASE_ZERO_CLOCK_OUT)
      else $error("phase zero not aligned to source rise");
   chk_half_phase: assert property (st_r == ST_RUN && duty_fix &&
      per >= PW'(4) && ph_r == h_off |=> HALF_PHASE_CLOCK_OUT && !PHASE_ZERO_CLOCK_OUT)
      else $error("half phase not at half period");
   chk_dbl_prelock: assert property (!locked && active && ph_r >= q_off |=>
      !DOUBLED_CLOCK_OUT)
      else $error("doubled output not quarter duty before lock");
   chk_duty_follow: assert property (!duty_fix && active && ph_r >= hi_t |=>
      !PHASE_ZERO_CLOCK_OUT)
      else $error("phase zero ignores source duty");
   chk_div_start: assert property (active && dv_r == '0 && dv_high != '0 |=>
      DIVIDED_CLOCK_OUT)
      else $error("divided output low at start of its period");
endmodule

// [dv/dlcm_src_model.sv]
// Purpose: oscillator model feeding the selected source lane
// Assumes: levels change right after MCLK edges, period fixed per run
// Notes:   unselected lanes sit low, as a stopped clock would
`timescale 1ns/10ps
module dlcm_src_model (
   input  wire logic        mclk,
   input  wire logic        run,
   input  wire logic [1:0]  lane,
   input  wire logic [11:0] period,
   input  wire logic [11:0] high_t,
   output logic [3:0]       src
);
   logic [11:0] cnt_r = 12'h000;
   logic        park_r = 1'b1;
   // parks only at a period boundary, so a pause always sits in a low phase
   always_ff @(posedge mclk) begin
      if (park_r) begin
         if (run) begin
            park_r <= 1'b0;
            cnt_r  <= 12'h000;
         end
      end else if (cnt_r >= period - 12'h001) begin
         cnt_r  <= 12'h000;
         park_r <= !run;
      end else begin
         cnt_r <= cnt_r + 12'h001;
      end
   end
   // a restart opens with a full high phase
   always_comb begin
      src       = 4'h0;
      src[lane] = !park_r && (cnt_r < high_t);
   end
endmodule

// [dv/delay_locked_clock_manager_bench.sv]
// Purpose: self-checking bench for the delay-locked clock manager
// Assumes: source period of 8 MCLK cycles, so each lock takes 24000 cycles
// Notes:   output clocks are judged only once locked, as a user would, apart from an all-low check right after reset
`timescale 1ns/10ps
module delay_locked_clock_manager_bench
   import dlcm_pkg::*;
;
   localparam int P = 8;
   int          hv [8] = '{3, 4, 5, 6, 8, 10, 16, 32};
   logic        MCLK = 1'b0;
   logic        RESETN = 1'b0;
   logic        CFG_DONE = 1'b0;
   logic [3:0]  AVS_ADDRESS = 4'h0;
   logic        AVS_READ = 1'b0;
   logic        AVS_WRITE = 1'b0;
   logic [31:0] AVS_WRITEDATA = 32'h0;
   logic [3:0]  AVS_BYTEENABLE = 4'hF;
   wire  [31:0] AVS_READDATA;
   wire         AVS_WAITREQUEST;
   wire  [5:0]  outs;
   wire         LOCKED;
   wire         STARTUP_RELEASE;
   wire  [3:0]  src;
   logic        run = 1'b1;
   logic [1:0]  ln = 2'h0;
   logic [11:0] high_t = 12'h004;
   int          n_fail = 0;
   int          total_checks = 0;
   int          hi, per, c, n, h;
   logic [31:0] rd;
   logic        early, bad, pz;

   always #4 MCLK = ~MCLK;

   dlcm_top dut_u (.MCLK(MCLK), .RESETN(RESETN), .SOURCE_CLOCK_IN(src), .CFG_DONE(CFG_DONE),
      .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
      .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
      .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
      .PHASE_ZERO_CLOCK_OUT(outs[0]), .QUARTER_PHASE_CLOCK_OUT(outs[1]),
      .HALF_PHASE_CLOCK_OUT(outs[2]), .THREE_QUARTER_PHASE_CLOCK_OUT(outs[3]),
      .DOUBLED_CLOCK_OUT(outs[4]), .DIVIDED_CLOCK_OUT(outs[5]), .LOCKED(LOCKED),
      .STARTUP_RELEASE(STARTUP_RELEASE));

   dlcm_src_model src_u (.mclk(MCLK), .run(run), .lane(ln), .period(12'(P)), .high_t(high_t),
      .src(src));

   function automatic logic [31:0] cw(input logic duty, input logic fast, input logic [2:0] code,
                                      input logic [1:0] pl, input logic rst);
      return {19'h0, rst, 2'h0, pl, 1'b0, code, 1'b0, fast, 1'b1, duty};
   endfunction

   task chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %0t %s: seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   task conclude;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // request held until waitrequest is sampled low at a rising edge
   task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge MCLK);
      AVS_ADDRESS   <= a;
      AVS_WRITEDATA <= d;
      AVS_READ      <= !wr;
      AVS_WRITE     <= wr;
      do begin
         @(posedge MCLK);
         k++;
      end while (AVS_WAITREQUEST !== 1'b0 && k < 20);
      rd = AVS_READDATA;
      AVS_READ  <= 1'b0;
      AVS_WRITE <= 1'b0;
      if (k >= 20) begin
         chk(1, 0, "bus hang");
         conclude;
      end
   endtask

   // cycles to the next sampled rise of one output, counting high samples on the way
   task edge_wait(input int idx);
      logic prev;
      prev = 1'b1;
      c = 0;
      hi = 1;
      while (c < 400) begin
         @(posedge MCLK);
         c++;
         if (prev === 1'b0 && outs[idx] === 1'b1) break;
         if (outs[idx] === 1'b1) hi++;
         prev = outs[idx];
      end
      if (c >= 400) begin
         chk(0, 1, "no output edge");
         conclude;
      end
   endtask

   task hi_per(input int idx);
      edge_wait(idx);
      edge_wait(idx);
      edge_wait(idx);
      per = c;
   endtask

   task wait_lock;
      int k;
      k = 0;
      early = 1'b0;
      while (LOCKED !== 1'b1 && k < 3100 * P) begin
         @(posedge MCLK);
         k++;
         if (LOCKED !== 1'b1 && STARTUP_RELEASE === 1'b1) early = 1'b1;
      end
      chk(32'(k >= 2998 * P), 1, "lock came too early");
      chk(32'(k < 3100 * P), 1, "lock never came");
      if (k >= 3100 * P) conclude;
   endtask

   initial begin
      void'($urandom(37));
      ln <= 2'($urandom % 4);
      h = 2 + ($urandom % 4);
      if (h >= P / 2) h++;
      high_t <= 12'(h);
      repeat (3) @(posedge MCLK);
      RESETN <= 1'b1;
      @(posedge MCLK);
      chk({outs, LOCKED, STARTUP_RELEASE}, 0, "outputs after reset");
      bus(0, OFF_CTRL, 0);
      chk(rd, 32'h0000_0011, "control defaults");
      bus(0, 4'hC, 0);
      chk(rd, 0, "unmapped read");
      bus(1, 4'hC, 32'hFFFF_FFFF);
      bus(1, OFF_CTRL, cw(1, 0, 3'h1, ln, 0));
      CFG_DONE <= 1'b1;
      wait_lock();
      chk(early, 0, "start-up released before lock");
      repeat (4) @(posedge MCLK);
      chk(STARTUP_RELEASE, 1, "start-up held after lock");
      bus(0, OFF_STATUS, 0);
      chk(rd[0], 1, "status lock bit");
      // output waveforms judged from here on; before lock only the all-low check after reset
      hi_per(0);
      chk(hi, P / 2, "phase zero high time");
      chk(per, P, "phase zero period");
      for (int i = 1; i < 4; i++) begin
         edge_wait(0);
         edge_wait(i);
         chk(c, i * P / 4, "phase lag");
      end
      for (int k = 0; k < 8; k++) begin
         bus(1, OFF_CTRL, cw(1, 0, 3'(k), ln, 0));
         hi_per(5);
         chk(per, (P * hv[k]) >> 1, "divided period");
         chk(hi, per >> 1, "divided high time");
      end
      for (int k = 0; k < 3; k += 2) begin
         bus(1, OFF_CTRL, cw(1, 1, 3'(k), ln, 0));
         hi_per(5);
         chk(hi, (P * (hv[k] >> 1)) >> 1, "high-frequency divided high");
      end
      bad = 1'b0;
      repeat (2 * P) begin
         @(posedge MCLK);
         if (outs[1] !== 1'b0 || outs[3] !== 1'b0) bad = 1'b1;
      end
      chk(bad, 0, "quarter phases in high-frequency mode");
      hi_per(2);
      chk(per, P, "half phase in high-frequency mode");
      bus(1, OFF_CTRL, cw(0, 0, 3'h1, ln, 0));
      hi_per(0);
      chk(hi, h, "uncorrected high time");
      // source period never changes, so no drift reset is owed
      run <= 1'b0;
      n = 0;
      bad = 1'b0;
      pz = outs[0];
      repeat (12 * P) begin
         @(posedge MCLK);
         if (LOCKED !== 1'b1) bad = 1'b1;
         if (pz === 1'b0 && outs[0] === 1'b1) n++;
         pz = outs[0];
      end
      chk(32'(n >= 1 && n <= 4), 1, "clocks after stop");
      chk(outs[0], 0, "output idle while stopped");
      run <= 1'b1;
      edge_wait(0);
      chk(32'(c >= P && c <= 4 * P + 4), 1, "delay after restart");
      chk({bad, LOCKED}, 1, "lock across pause");
      ln <= ln + 2'h1;
      bus(1, OFF_CTRL, cw(1, 0, 3'h1, ln + 2'h1, 1));
      repeat (3) @(posedge MCLK);
      chk(LOCKED, 0, "lock after manual reset");
      bus(0, OFF_CTRL, 0);
      chk(rd, cw(1, 0, 3'h1, ln, 0), "control after manual reset");
      wait_lock();
      chk(STARTUP_RELEASE, 1, "start-up release kept");
      hi_per(0);
      chk(per, P, "period on new placement");
      conclude;
   end
endmodule
